// file: core/scb_pkg.sv
/*
 Constants and carrier types for the system control register bank.
 Assumes a byte-wide register port driven by the processor core.
*/
package scb_pkg;

   // -----------------------------------------------------------------
   // Sizes
   // -----------------------------------------------------------------
   localparam int SCB_NREG = 27;

   // -----------------------------------------------------------------
   // Byte addresses
   // -----------------------------------------------------------------
   localparam logic [7:0] SCB_OFF_PM0 = 8'h04;
   localparam logic [7:0] SCB_OFF_PM1 = 8'h05;
   localparam logic [7:0] SCB_OFF_CLK0 = 8'h06;
   localparam logic [7:0] SCB_OFF_CLK1 = 8'h07;
   localparam logic [7:0] SCB_OFF_MSTBY = 8'h08;
   localparam logic [7:0] SCB_OFF_CLK3 = 8'h09;
   localparam logic [7:0] SCB_OFF_WPROT = 8'h0A;
   localparam logic [7:0] SCB_OFF_RCAUSE = 8'h0B;
   localparam logic [7:0] SCB_OFF_OSTOP = 8'h0C;
   localparam logic [7:0] SCB_OFF_WDREF = 8'h0D;
   localparam logic [7:0] SCB_OFF_WDSTART = 8'h0E;
   localparam logic [7:0] SCB_OFF_WDCTRL = 8'h0F;
   localparam logic [7:0] SCB_OFF_HSO7 = 8'h15;
   localparam logic [7:0] SCB_OFF_CSPROT = 8'h1C;
   localparam logic [7:0] SCB_OFF_HSO0 = 8'h23;
   localparam logic [7:0] SCB_OFF_HSO1 = 8'h24;
   localparam logic [7:0] SCB_OFF_HSO2 = 8'h25;
   localparam logic [7:0] SCB_OFF_REFV = 8'h26;
   localparam logic [7:0] SCB_OFF_PSRF = 8'h28;
   localparam logic [7:0] SCB_OFF_HSO4 = 8'h29;
   localparam logic [7:0] SCB_OFF_HSO5 = 8'h2A;
   localparam logic [7:0] SCB_OFF_HSO6 = 8'h2B;
   localparam logic [7:0] SCB_OFF_HSO3 = 8'h2F;
   localparam logic [7:0] SCB_OFF_CMPCTL = 8'h30;
   localparam logic [7:0] SCB_OFF_EDGESEL = 8'h31;
   localparam logic [7:0] SCB_OFF_VDET1 = 8'h33;
   localparam logic [7:0] SCB_OFF_VDET2 = 8'h34;
   localparam logic [7:0] SCB_OFF_D1LVL = 8'h36;
   localparam logic [7:0] SCB_OFF_VMON0 = 8'h38;
   localparam logic [7:0] SCB_OFF_VMON1 = 8'h39;

   // -----------------------------------------------------------------
   // Storage indices
   // -----------------------------------------------------------------
   localparam logic [4:0] SCB_IDX_PM0 = 5'h00;
   localparam logic [4:0] SCB_IDX_PM1 = 5'h01;
   localparam logic [4:0] SCB_IDX_CLK0 = 5'h02;
   localparam logic [4:0] SCB_IDX_CLK1 = 5'h03;
   localparam logic [4:0] SCB_IDX_MSTBY = 5'h04;
   localparam logic [4:0] SCB_IDX_CLK3 = 5'h05;
   localparam logic [4:0] SCB_IDX_WPROT = 5'h06;
   localparam logic [4:0] SCB_IDX_OSTOP = 5'h07;
   localparam logic [4:0] SCB_IDX_WDCTRL = 5'h08;
   localparam logic [4:0] SCB_IDX_HSO7 = 5'h09;
   localparam logic [4:0] SCB_IDX_CSPROT = 5'h0A;
   localparam logic [4:0] SCB_IDX_HSO0 = 5'h0B;
   localparam logic [4:0] SCB_IDX_HSO1 = 5'h0C;
   localparam logic [4:0] SCB_IDX_HSO2 = 5'h0D;
   localparam logic [4:0] SCB_IDX_REFV = 5'h0E;
   localparam logic [4:0] SCB_IDX_PSRF = 5'h0F;
   localparam logic [4:0] SCB_IDX_HSO4 = 5'h10;
   localparam logic [4:0] SCB_IDX_HSO5 = 5'h11;
   localparam logic [4:0] SCB_IDX_HSO6 = 5'h12;
   localparam logic [4:0] SCB_IDX_HSO3 = 5'h13;
   localparam logic [4:0] SCB_IDX_CMPCTL = 5'h14;
   localparam logic [4:0] SCB_IDX_EDGESEL = 5'h15;
   localparam logic [4:0] SCB_IDX_VDET1 = 5'h16;
   localparam logic [4:0] SCB_IDX_VDET2 = 5'h17;
   localparam logic [4:0] SCB_IDX_D1LVL = 5'h18;
   localparam logic [4:0] SCB_IDX_VMON0 = 5'h19;
   localparam logic [4:0] SCB_IDX_VMON1 = 5'h1A;

   // -----------------------------------------------------------------
   // Reset values and field positions
   // -----------------------------------------------------------------
   localparam logic [7:0] SCB_RST_ZERO = 8'h00;
   localparam logic [7:0] SCB_RST_CLK0 = 8'h28;
   localparam logic [7:0] SCB_RST_CLK1 = 8'h10;
   localparam logic [7:0] SCB_RST_OSTOP = 8'h04;
   localparam logic [7:0] SCB_RST_WDCTRL = 8'h3F;
   localparam logic [7:0] SCB_RST_VDET1 = 8'h08;
   localparam logic [7:0] SCB_RST_D1LVL = 8'h07;
   localparam logic [7:0] SCB_RST_VMON0 = 8'hC2;
   localparam logic [7:0] SCB_RST_VMON1 = 8'h8A;
   localparam logic [7:0] SCB_RST_CSPROT_OPT = 8'h40;
   localparam logic [7:0] SCB_RST_VDET2_OPT = 8'h20;
   localparam int SCB_BIT_COLD = 0;

   // -----------------------------------------------------------------
   // Carrier types
   // -----------------------------------------------------------------
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } scb_req_t;

   typedef struct packed {
      logic [7:0] hso1;
      logic [7:0] hso3;
      logic [7:0] hso4;
      logic [7:0] hso5;
      logic [7:0] hso6;
      logic [7:0] hso7;
   } scb_trim_t;

   typedef struct packed {
      logic hit;
      logic [4:0] idx;
   } scb_map_t;

   typedef logic [SCB_NREG-1:0][7:0] scb_regs_t;

endpackage

// file: core/scb_sfr_bank.sv
/*
 Byte-wide system control register bank with its register port.
 Assumes a synchronous core port, an option byte and trim fuses that
 are stable at the first clock edge after rst falls, and a separate cold reset source.
*/
// What this block does
// - Unmapped addresses are reserved, reads return zero
// - Cold reset clears the cold-start flag
// - Other resets leave the cold-start flag alone
// - Reset cause reads with top bit zero
// - Count protect resets per its option bit
// - Voltage detect 2 resets per option bit
// - Voltage monitor 0 control resets to 1100X010b
// - Clock control 0 resets to 28h
// - Clock control 1 resets to 10h
// - Oscillation stop detect resets to 04h
// - Watchdog control 3Fh; refresh, start undefined
// - Oscillator trim registers HSO1 and HSO3 to HSO7 load factory values
// - Voltage detect 1 resets to 08h
// - Detect 1 level select resets to 07h
// - Voltage monitor 1 control resets to 8Ah
// - Remaining listed registers reset to 00h
`timescale 1ns/1ps
`default_nettype none
module scb_sfr_bank
   import scb_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic coldRst,
   input wire scb_req_t busReq,
   input wire logic countProtectInitialOption,
   input wire logic lowVoltageDetectOption,
   input wire scb_trim_t trimFuse,
   output logic [7:0] rdData,
   output scb_regs_t regFile,
   output logic coldStartFlag,
   output logic wdtRefreshPulse,
   output logic wdtStartPulse
);

   // ----------------------------------------------------------------
   // Decode helpers
   // ----------------------------------------------------------------
   function automatic scb_map_t regIndex(input logic [7:0] addr);
      scb_map_t m;
      m.hit = 1'b1;
      m.idx = SCB_IDX_PM0;
      unique case (addr)
         SCB_OFF_PM0: m.idx = SCB_IDX_PM0;
         SCB_OFF_PM1: m.idx = SCB_IDX_PM1;
         SCB_OFF_CLK0: m.idx = SCB_IDX_CLK0;
         SCB_OFF_CLK1: m.idx = SCB_IDX_CLK1;
         SCB_OFF_MSTBY: m.idx = SCB_IDX_MSTBY;
         SCB_OFF_CLK3: m.idx = SCB_IDX_CLK3;
         SCB_OFF_WPROT: m.idx = SCB_IDX_WPROT;
         SCB_OFF_OSTOP: m.idx = SCB_IDX_OSTOP;
         SCB_OFF_WDCTRL: m.idx = SCB_IDX_WDCTRL;
         SCB_OFF_HSO7: m.idx = SCB_IDX_HSO7;
         SCB_OFF_CSPROT: m.idx = SCB_IDX_CSPROT;
         SCB_OFF_HSO0: m.idx = SCB_IDX_HSO0;
         SCB_OFF_HSO1: m.idx = SCB_IDX_HSO1;
         SCB_OFF_HSO2: m.idx = SCB_IDX_HSO2;
         SCB_OFF_REFV: m.idx = SCB_IDX_REFV;
         SCB_OFF_PSRF: m.idx = SCB_IDX_PSRF;
         SCB_OFF_HSO4: m.idx = SCB_IDX_HSO4;
         SCB_OFF_HSO5: m.idx = SCB_IDX_HSO5;
         SCB_OFF_HSO6: m.idx = SCB_IDX_HSO6;
         SCB_OFF_HSO3: m.idx = SCB_IDX_HSO3;
         SCB_OFF_CMPCTL: m.idx = SCB_IDX_CMPCTL;
         SCB_OFF_EDGESEL: m.idx = SCB_IDX_EDGESEL;
         SCB_OFF_VDET1: m.idx = SCB_IDX_VDET1;
         SCB_OFF_VDET2: m.idx = SCB_IDX_VDET2;
         SCB_OFF_D1LVL: m.idx = SCB_IDX_D1LVL;
         SCB_OFF_VMON0: m.idx = SCB_IDX_VMON0;
         SCB_OFF_VMON1: m.idx = SCB_IDX_VMON1;
         default: m.hit = 1'b0;
      endcase
      return m;
   endfunction

   function automatic logic [7:0] rstValue(input logic [4:0] idx);
      logic [7:0] v;
      v = SCB_RST_ZERO;
      unique case (idx)
         SCB_IDX_CLK0: v = SCB_RST_CLK0;
         SCB_IDX_CLK1: v = SCB_RST_CLK1;
         SCB_IDX_OSTOP: v = SCB_RST_OSTOP;
         SCB_IDX_WDCTRL: v = SCB_RST_WDCTRL;
         SCB_IDX_VDET1: v = SCB_RST_VDET1;
         SCB_IDX_D1LVL: v = SCB_RST_D1LVL;
         SCB_IDX_VMON0: v = SCB_RST_VMON0;
         SCB_IDX_VMON1: v = SCB_RST_VMON1;
         default: v = SCB_RST_ZERO;
      endcase
      return v;
   endfunction

   function automatic logic isReadOnly(input logic [4:0] idx);
      return (idx == SCB_IDX_HSO7) || (idx == SCB_IDX_HSO4) ||
         (idx == SCB_IDX_HSO5) || (idx == SCB_IDX_HSO6);
   endfunction

   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   scb_regs_t regs_ff;
   logic initDone_ff;
   logic coldStart_ff;
   logic [7:0] rdData_ff;
   logic wdtRefresh_ff;
   logic wdtStart_ff;
   logic [7:0] nxt_rdData;
   scb_map_t wrMap;
   scb_map_t rdMap;
   logic coldWrite;

   assign wrMap = regIndex(busReq.addr);
   assign rdMap = regIndex(busReq.addr);
   assign coldWrite = busReq.wr && (busReq.addr == SCB_OFF_RCAUSE);

   // ----------------------------------------------------------------
   // Option and trim capture on the first edge after release
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         initDone_ff <= 1'b0;
      end else begin
         initDone_ff <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Register array
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < SCB_NREG; i++) begin
            regs_ff[i] <= rstValue(5'(i));
         end
      end else if (!initDone_ff) begin
         regs_ff[SCB_IDX_CSPROT] <= countProtectInitialOption ?
            SCB_RST_ZERO : SCB_RST_CSPROT_OPT;
         regs_ff[SCB_IDX_VDET2] <= lowVoltageDetectOption ?
            SCB_RST_ZERO : SCB_RST_VDET2_OPT;
         regs_ff[SCB_IDX_HSO1] <= trimFuse.hso1;
         regs_ff[SCB_IDX_HSO3] <= trimFuse.hso3;
         regs_ff[SCB_IDX_HSO4] <= trimFuse.hso4;
         regs_ff[SCB_IDX_HSO5] <= trimFuse.hso5;
         regs_ff[SCB_IDX_HSO6] <= trimFuse.hso6;
         regs_ff[SCB_IDX_HSO7] <= trimFuse.hso7;
      end else if (busReq.wr && wrMap.hit && !isReadOnly(wrMap.idx)) begin
         regs_ff[wrMap.idx] <= busReq.wdata;
      end
   end

   // ----------------------------------------------------------------
   // Cold-start flag, untouched by rst
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk or posedge coldRst) begin
      if (coldRst) begin
         coldStart_ff <= 1'b0;
      end else if (coldWrite) begin
         coldStart_ff <= busReq.wdata[SCB_BIT_COLD];
      end
   end

   // ----------------------------------------------------------------
   // Watchdog strobes
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         wdtRefresh_ff <= 1'b0;
         wdtStart_ff <= 1'b0;
      end else begin
         wdtRefresh_ff <= busReq.wr && (busReq.addr == SCB_OFF_WDREF);
         wdtStart_ff <= busReq.wr && (busReq.addr == SCB_OFF_WDSTART);
      end
   end

   // ----------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------
   always_comb begin
      nxt_rdData = SCB_RST_ZERO;
      if (busReq.rd) begin
         if (rdMap.hit) begin
            nxt_rdData = regs_ff[rdMap.idx];
         end else if (busReq.addr == SCB_OFF_RCAUSE) begin
            nxt_rdData = SCB_RST_ZERO;
            nxt_rdData[SCB_BIT_COLD] = coldStart_ff;
         end
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rdData_ff <= SCB_RST_ZERO;
      end else begin
         rdData_ff <= nxt_rdData;
      end
   end

   assign rdData = rdData_ff;
   assign regFile = regs_ff;
   assign coldStartFlag = coldStart_ff;
   assign wdtRefreshPulse = wdtRefresh_ff;
   assign wdtStartPulse = wdtStart_ff;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   sequence s_initCycle;
      !initDone_ff;
   endsequence

   sequence s_loadEdge;
      $rose(initDone_ff);
   endsequence

   sequence s_writeAt(logic [7:0] a);
      busReq.wr && (busReq.addr == a);
   endsequence

   sequence s_readAt(logic [7:0] a);
      busReq.rd && (busReq.addr == a);
   endsequence

   property p_unmappedRead;
      @(posedge sys_clk) disable iff (rst)
      busReq.rd && !rdMap.hit && (busReq.addr != SCB_OFF_RCAUSE)
      |=> rdData == SCB_RST_ZERO;
   endproperty
   a_unmappedRead: assert property (p_unmappedRead)
      else $error("unmapped read returned nonzero");

   property p_coldClear;
      @(posedge sys_clk) disable iff (rst)
      coldRst |-> !coldStartFlag;
   endproperty
   a_coldClear: assert property (p_coldClear)
      else $error("cold-start flag not cleared by cold reset");

   property p_coldKeep;
      @(posedge sys_clk) disable iff (coldRst)
      !coldWrite |=> coldStartFlag == $past(coldStartFlag);
   endproperty
   a_coldKeep: assert property (p_coldKeep)
      else $error("cold-start flag changed without a write");

   property p_causeRead;
      @(posedge sys_clk) disable iff (rst)
      s_readAt(SCB_OFF_RCAUSE) |=> !rdData[7] &&
         (rdData[SCB_BIT_COLD] == $past(coldStartFlag));
   endproperty
   a_causeRead: assert property (p_causeRead)
      else $error("reset cause read wrong");

   property p_csprInit;
      @(posedge sys_clk) disable iff (rst)
      s_loadEdge |-> regFile[SCB_IDX_CSPROT] ==
         ($past(countProtectInitialOption) ? SCB_RST_ZERO :
         SCB_RST_CSPROT_OPT);
   endproperty
   a_csprInit: assert property (p_csprInit)
      else $error("count protect reset value wrong");

   property p_vdet2Init;
      @(posedge sys_clk) disable iff (rst)
      s_loadEdge |-> regFile[SCB_IDX_VDET2] ==
         ($past(lowVoltageDetectOption) ? SCB_RST_ZERO : SCB_RST_VDET2_OPT);
   endproperty
   a_vdet2Init: assert property (p_vdet2Init)
      else $error("voltage detect 2 reset value wrong");

   property p_vmon0Rst;
      @(posedge sys_clk) disable iff (rst)
      s_initCycle |-> regFile[SCB_IDX_VMON0][7:4] == SCB_RST_VMON0[7:4] &&
         regFile[SCB_IDX_VMON0][2:0] == SCB_RST_VMON0[2:0];
   endproperty
   a_vmon0Rst: assert property (p_vmon0Rst)
      else $error("voltage monitor 0 reset value wrong");

   property p_fixedRst;
      @(posedge sys_clk) disable iff (rst)
      s_initCycle |-> regFile[SCB_IDX_CLK0] == SCB_RST_CLK0 &&
         regFile[SCB_IDX_CLK1] == SCB_RST_CLK1 &&
         regFile[SCB_IDX_OSTOP] == SCB_RST_OSTOP &&
         regFile[SCB_IDX_WDCTRL] == SCB_RST_WDCTRL;
   endproperty
   a_fixedRst: assert property (p_fixedRst)
      else $error("clock or watchdog reset value wrong");

   property p_trimLoad;
      @(posedge sys_clk) disable iff (rst)
      s_loadEdge |-> regFile[SCB_IDX_HSO7] == $past(trimFuse.hso7) &&
         regFile[SCB_IDX_HSO1] == $past(trimFuse.hso1);
   endproperty
   a_trimLoad: assert property (p_trimLoad)
      else $error("trim value not loaded");

   property p_vdetRst;
      @(posedge sys_clk) disable iff (rst)
      s_initCycle |-> regFile[SCB_IDX_VDET1] == SCB_RST_VDET1 &&
         regFile[SCB_IDX_D1LVL] == SCB_RST_D1LVL &&
         regFile[SCB_IDX_VMON1] == SCB_RST_VMON1;
   endproperty
   a_vdetRst: assert property (p_vdetRst)
      else $error("voltage detect reset value wrong");

   property p_zeroRst;
      @(posedge sys_clk) disable iff (rst)
      s_initCycle |-> regFile[SCB_IDX_PM0] == SCB_RST_ZERO &&
         regFile[SCB_IDX_WPROT] == SCB_RST_ZERO &&
         regFile[SCB_IDX_PSRF] == SCB_RST_ZERO &&
         regFile[SCB_IDX_EDGESEL] == SCB_RST_ZERO;
   endproperty
   a_zeroRst: assert property (p_zeroRst)
      else $error("register not zero after reset");

   property p_byteWrite;
      @(posedge sys_clk) disable iff (rst)
      initDone_ff && busReq.wr && wrMap.hit && !isReadOnly(wrMap.idx)
      ##1 busReq.rd && (busReq.addr == $past(busReq.addr))
      |=> rdData == $past(busReq.wdata, 2);
   endproperty
   a_byteWrite: assert property (p_byteWrite)
      else $error("written byte not read back");

   property p_wdtPulse;
      @(posedge sys_clk) disable iff (rst)
      s_writeAt(SCB_OFF_WDREF) |=> wdtRefreshPulse ##1
         (!wdtRefreshPulse ||
         $past(busReq.wr && (busReq.addr == SCB_OFF_WDREF)));
   endproperty
   a_wdtPulse: assert property (p_wdtPulse)
      else $error("watchdog refresh strobe wrong");

   property p_wdtStart;
      @(posedge sys_clk) disable iff (rst)
      s_writeAt(SCB_OFF_WDSTART) |=> wdtStartPulse ##1
         (!wdtStartPulse ||
         $past(busReq.wr && (busReq.addr == SCB_OFF_WDSTART)));
   endproperty
   a_wdtStart: assert property (p_wdtStart)
      else $error("watchdog start strobe wrong");

   property p_rdIdle;
      @(posedge sys_clk) disable iff (rst)
      !busReq.rd |=> rdData == SCB_RST_ZERO;
   endproperty
   a_rdIdle: assert property (p_rdIdle)
      else $error("read data not cleared after read cycle");

   property p_roWrite;
      @(posedge sys_clk) disable iff (rst)
      initDone_ff && busReq.wr && wrMap.hit && isReadOnly(wrMap.idx)
      |=> $stable(regFile);
   endproperty
   a_roWrite: assert property (p_roWrite)
      else $error("read-only trim register changed by a write");

   property p_unmappedWrite;
      @(posedge sys_clk) disable iff (rst)
      initDone_ff && busReq.wr && !wrMap.hit |=> $stable(regFile);
   endproperty
   a_unmappedWrite: assert property (p_unmappedWrite)
      else $error("unmapped write changed a register");

   property p_coldWrite;
      @(posedge sys_clk) disable iff (coldRst)
      coldWrite |=> coldStartFlag == $past(busReq.wdata[SCB_BIT_COLD]);
   endproperty
   a_coldWrite: assert property (p_coldWrite)
      else $error("cold-start flag write not taken");

endmodule
`default_nettype wire

// file: sim/tb_scb_sfr_bank.sv
/*
 Self-checking testbench for the system control register bank.
 Assumes the register port, reset and option timing of the hand-over
 note; a bench model of every register predicts each read.
*/
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) \
   begin \
      numChecks++; \
      if ((got) !== (exp)) begin \
         errCount++; \
         $display("ERROR t=%0t got=%0h exp=%0h", $time, (got), (exp)); \
      end \
   end

module tb_scb_sfr_bank
   import scb_pkg::*;
;
   logic sysClk = 1'b0;
   logic rst = 1'b1;
   logic coldRst = 1'b1;
   scb_req_t busReq = '0;
   logic countProtectInitialOption = 1'b1;
   logic lowVoltageDetectOption = 1'b1;
   scb_trim_t trimFuse = '0;
   logic [7:0] rdData;
   scb_regs_t regFile;
   logic coldStartFlag;
   logic wdtRefreshPulse;
   logic wdtStartPulse;
   int errCount = 0;
   int numChecks = 0;
   integer seed = 99685;
   logic [7:0] shadow [0:255];
   logic coldExp = 1'b0;

   // ----------------------------------------------------------------
   // Clock and device
   // ----------------------------------------------------------------
   always #20 sysClk = ~sysClk;

   scb_sfr_bank u_scb_sfr_bank (
      .sys_clk(sysClk),
      .rst(rst),
      .coldRst(coldRst),
      .busReq(busReq),
      .countProtectInitialOption(countProtectInitialOption),
      .lowVoltageDetectOption(lowVoltageDetectOption),
      .trimFuse(trimFuse),
      .rdData(rdData),
      .regFile(regFile),
      .coldStartFlag(coldStartFlag),
      .wdtRefreshPulse(wdtRefreshPulse),
      .wdtStartPulse(wdtStartPulse)
   );

   // ----------------------------------------------------------------
   // Expected values
   // ----------------------------------------------------------------
   function automatic logic [7:0] rstVal(input logic [7:0] a);
      case (a)
         SCB_OFF_CLK0: rstVal = 8'h28;
         SCB_OFF_CLK1: rstVal = 8'h10;
         SCB_OFF_OSTOP: rstVal = 8'h04;
         SCB_OFF_WDCTRL: rstVal = 8'h3F;
         SCB_OFF_VDET1: rstVal = 8'h08;
         SCB_OFF_D1LVL: rstVal = 8'h07;
         SCB_OFF_VMON0: rstVal = 8'hC2;
         SCB_OFF_VMON1: rstVal = 8'h8A;
         SCB_OFF_CSPROT: rstVal = countProtectInitialOption ? 8'h00 : 8'h40;
         SCB_OFF_VDET2: rstVal = lowVoltageDetectOption ? 8'h00 : 8'h20;
         SCB_OFF_HSO1: rstVal = trimFuse.hso1;
         SCB_OFF_HSO3: rstVal = trimFuse.hso3;
         SCB_OFF_HSO4: rstVal = trimFuse.hso4;
         SCB_OFF_HSO5: rstVal = trimFuse.hso5;
         SCB_OFF_HSO6: rstVal = trimFuse.hso6;
         SCB_OFF_HSO7: rstVal = trimFuse.hso7;
         default: rstVal = 8'h00;
      endcase
   endfunction

   function automatic logic isWr(input logic [7:0] a);
      case (a)
         8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0A, 8'h0C, 8'h0F,
         8'h1C, 8'h23, 8'h24, 8'h25, 8'h26, 8'h28, 8'h2F, 8'h30, 8'h31,
         8'h33, 8'h34, 8'h36, 8'h38, 8'h39: isWr = 1'b1;
         default: isWr = 1'b0;
      endcase
   endfunction

   function automatic logic [7:0] expRead(input logic [7:0] a);
      expRead = (a == 8'h0B) ? {7'h00, coldExp} : shadow[a];
   endfunction

   // ----------------------------------------------------------------
   // Bus and reset tasks
   // ----------------------------------------------------------------
   task automatic busWrite(input logic [7:0] a, input logic [7:0] d);
      @(posedge sysClk);
      busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge sysClk);
      busReq.wr <= 1'b0;
      if (isWr(a))
         shadow[a] = d;
      if (a == 8'h0B)
         coldExp = d[0];
      #1;
      `CHK(wdtRefreshPulse, (a == 8'h0D))
      `CHK(wdtStartPulse, (a == 8'h0E))
      @(posedge sysClk);
      #1;
      `CHK({wdtRefreshPulse, wdtStartPulse}, 2'b00)
   endtask

   task automatic busRead(input logic [7:0] a);
      @(posedge sysClk);
      busReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge sysClk);
      busReq.rd <= 1'b0;
      #1;
      `CHK(rdData, expRead(a))
   endtask

   task automatic busWriteRead(input logic [7:0] a, input logic [7:0] d);
      @(posedge sysClk);
      busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge sysClk);
      busReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      if (isWr(a))
         shadow[a] = d;
      if (a == 8'h0B)
         coldExp = d[0];
      @(posedge sysClk);
      busReq.rd <= 1'b0;
      #1;
      `CHK(rdData, expRead(a))
   endtask

   task automatic applyRst(input logic cs, input logic lv, input logic cold);
      logic [63:0] r;
      r = {$random(seed), $random(seed)};
      @(posedge sysClk);
      rst <= 1'b1;
      coldRst <= cold;
      countProtectInitialOption <= cs;
      lowVoltageDetectOption <= lv;
      trimFuse <= r[47:0];
      repeat (10) @(posedge sysClk);
      rst <= 1'b0;
      coldRst <= 1'b0;
      repeat (2) @(posedge sysClk);
      #1;
      if (cold)
         coldExp = 1'b0;
      for (int i = 0; i < 256; i++)
         shadow[i] = rstVal(8'(i));
   endtask

   task automatic sweep();
      for (int i = 0; i < 64; i++)
         busRead(8'(i));
      busRead(8'hFF);
   endtask

   task automatic completeRun();
      $display("checks %0d mismatches %0d", numChecks, errCount);
      if (errCount == 0 && numChecks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Hang guard
   // ----------------------------------------------------------------
   initial begin
      repeat (20000) @(posedge sysClk);
      errCount++;
      completeRun();
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      logic [31:0] r;
      logic [7:0] a;
      for (int m = 0; m < 4; m++) begin
         applyRst(m[0], m[1], (m == 0));
         `CHK(coldStartFlag, coldExp)
         `CHK(regFile[SCB_IDX_CSPROT], (m[0] ? 8'h00 : 8'h40))
         `CHK(regFile[SCB_IDX_VDET2], (m[1] ? 8'h00 : 8'h20))
         `CHK(regFile[SCB_IDX_CLK0], 8'h28)
         sweep();
         $display("test reset values mode %0d done", m);
         for (int k = 0; k < 80; k++) begin
            r = $random(seed);
            a = (r[15:12] == 4'h0) ? r[23:16] : {2'b00, r[5:0]};
            if (r[9] && r[8])
               busWriteRead(a, r[31:24]);
            else if (r[8])
               busWrite(a, r[31:24]);
            else
               busRead(a);
         end
         busWriteRead(8'h24, 8'hC3);
         busWrite(8'h15, 8'hA5);
         busWrite(8'h3F, 8'h5A);
         sweep();
         $display("test random access mode %0d done", m);
      end
      busWrite(8'h0B, 8'hFF);
      `CHK(coldStartFlag, 1'b1)
      applyRst(1'b0, 1'b0, 1'b0);
      `CHK(coldStartFlag, 1'b1)
      busRead(8'h0B);
      @(posedge sysClk);
      coldRst <= 1'b1;
      @(posedge sysClk);
      coldRst <= 1'b0;
      coldExp = 1'b0;
      #1;
      `CHK(coldStartFlag, 1'b0)
      `CHK(regFile[SCB_IDX_CLK0], shadow[SCB_OFF_CLK0])
      busRead(8'h0B);
      $display("test cold start flag done");
      completeRun();
   end
endmodule
`default_nettype wire
